/* File: bench/pci_masters_model.sv */
`timescale 1ns/1ps
module pci_masters_model
    import arb_diag_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Pattern loaded by the bench
    input  wire logic       load_i,
    input  wire arb_pins_t  pat_i,
    input  wire logic [4:0] upper_i,
    input  wire logic [4:0] lower_i,
    // Lines seen by the observer
    output arb_pins_t       pins_o,
    output logic [4:0]      upper_o,
    output logic [4:0]      lower_o
);
    // Lines move one edge after a load; controller parked with grant
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_o  <= {1'b0, 4'hf, 1'b1, 4'hf};
            upper_o <= 5'h00;
            lower_o <= 5'h00;
        end else if (load_i) begin
            pins_o  <= pat_i;
            upper_o <= upper_i;
            lower_o <= lower_i;
        end
    end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import arb_diag_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    reg_req_t    req     = '0;
    logic        in_use  = 1'b0;
    logic        load    = 1'b0;
    arb_pins_t   pat     = '0;
    logic [4:0]  up_st   = 5'h00;
    logic [4:0]  lo_st   = 5'h00;
    arb_pins_t   pins;
    logic [4:0]  up_w;
    logic [4:0]  lo_w;
    logic [31:0] rd_data;
    logic [2:0]  agent;
    arb_phase_t  phase;
    int          fails = 0;
    int          checks_done = 0;
    // Free running clock
    initial forever #25 clock_i = ~clock_i;
    pci_masters_model pci_masters_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .load_i(load), .pat_i(pat), .upper_i(up_st), .lower_i(lo_st),
        .pins_o(pins), .upper_o(up_w), .lower_o(lo_w));
    arb_diag_observe arb_diag_observe_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .reg_req_i(req), .rd_data_o(rd_data), .arb_in_use_i(in_use), .pins_i(pins),
        .upper_state_i(up_w), .lower_state_i(lo_w),
        .observed_agent_o(agent), .observed_phase_o(phase));
    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Read one register, data checked in the following cycle
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock_i);
        req.rd <= 1'b0;
        #1;
        checks_done++;
        if (rd_data !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, rd_data, exp);
        end
    endtask
    // Decoded view compare
    task automatic chk_obs(input logic [2:0] ea, input arb_phase_t ep);
        checks_done++;
        if (agent !== ea || phase !== ep) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, {agent, phase}, {ea, ep});
        end
    endtask
    // One cycle write
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock_i);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clock_i);
        req.wr <= 1'b0;
    endtask
    // Load new line levels and let them settle into the snapshots
    task automatic drive(input arb_pins_t p, input logic [4:0] u, input logic [4:0] l);
        @(posedge clock_i);
        pat <= p;
        up_st <= u;
        lo_st <= l;
        load <= 1'b1;
        @(posedge clock_i);
        load <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask
    // Hang guard
    initial begin
        repeat (20_000) @(posedge clock_i);
        fails++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd_chk(REQ_SNAP_ADDR, 32'h0000_0000);
        rd_chk(GNT_SNAP_ADDR, 32'h0000_0080);
        rd_chk(STATE_VIEW_ADDR, 32'h0000_0000);
        rd_chk(16'hd120, 32'h0000_0000);
        drive({1'b1, 4'b0000, 1'b0, 4'b0000}, 5'h13, 5'h0f);
        rd_chk(REQ_SNAP_ADDR, 32'h0000_0000);
        rd_chk(GNT_SNAP_ADDR, 32'h0000_0080);
        $display("test reset and unused done");
        @(posedge clock_i) in_use <= 1'b1;
        drive({1'b1, 4'b1010, 1'b0, 4'b1110}, 5'h00, 5'h00);
        wr(REQ_SNAP_ADDR, 32'hffff_ffff);
        wr(GNT_SNAP_ADDR, 32'h0000_0000);
        rd_chk(REQ_SNAP_ADDR, 32'h0000_0085);
        rd_chk(GNT_SNAP_ADDR, 32'h0000_0001);
        $display("test mirrors done");
        wr(STATE_VIEW_ADDR, 32'hffff_ffff);
        for (int c = 0; c < 20; c++) begin
            drive(pat, c[4:0], ~c[4:0]);
            rd_chk(STATE_VIEW_ADDR, {24'h00_0000, 3'b100, c[4:0]});
            chk_obs(c[4:2], arb_phase_t'(c[1:0]));
        end
        $display("test upper view done");
        wr(STATE_VIEW_ADDR, 32'h0000_0000);
        for (int c = 0; c < 20; c++) begin
            drive(pat, ~c[4:0], c[4:0]);
            rd_chk(STATE_VIEW_ADDR, {28'h000_0000, c[3:0]});
        end
        $display("test lower view done");
        wr(STATE_VIEW_ADDR, 32'h0000_0080);
        rd_chk(STATE_VIEW_ADDR, 32'h0000_008c);
        @(posedge clock_i) rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd_chk(STATE_VIEW_ADDR, 32'h0000_0000);
        rd_chk(GNT_SNAP_ADDR, 32'h0000_0080);
        rd_chk(REQ_SNAP_ADDR, 32'h0000_0000);
        $display("test mid-run reset done");
        @(posedge clock_i) in_use <= 1'b0;
        drive(pat, 5'h00, 5'h00);
        rd_chk(GNT_SNAP_ADDR, 32'h0000_0080);
        $display("test release done");
        finish_test;
    end
endmodule

/* File: include/arb_diag_pkg.sv */
package arb_diag_pkg;

    // Register byte addresses
    localparam logic [15:0] REQ_SNAP_ADDR   = 16'hd114;
    localparam logic [15:0] GNT_SNAP_ADDR   = 16'hd118;
    localparam logic [15:0] STATE_VIEW_ADDR = 16'hd11c;

    // Reset values
    localparam logic [7:0]  REQ_SNAP_RST    = 8'h00;
    localparam logic [7:0]  GNT_SNAP_RST    = 8'h80;
    localparam logic        SEL_RST         = 1'b0;
    localparam logic [4:0]  CUR_STATE_RST   = 5'h00;

    // Field positions
    localparam int          SEL_BIT         = 7;
    localparam int          CTRL_BIT        = 7;
    localparam int          STATE_MSB       = 4;

    // View select encodings
    localparam logic        SEL_UPPER       = 1'b1;
    localparam logic        SEL_LOWER       = 1'b0;

    // Slot index of the lower-level agent inside the upper machine
    localparam logic [2:0]  SLOT_LOWER      = 3'h4;

    // Phase of a state code, its two low bits
    typedef enum logic [1:0] {
        PH_PREPARE    = 2'h0,
        PH_GNT_BUSY   = 2'h1,
        PH_GNT_IDLE   = 2'h2,
        PH_OWNER      = 2'h3
    } arb_phase_t;

    // Register port request from software
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Live arbiter pins, external request and grant lines are active low, controller lines active high
    typedef struct packed {
        logic       ctrl_req;
        logic [3:0] ext_req_n;
        logic       ctrl_gnt;
        logic [3:0] ext_gnt_n;
    } arb_pins_t;

endpackage

/* File: verilog/arb_diag_observe.sv */
`timescale 1ns/1ps
module arb_diag_observe
    import arb_diag_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire reg_req_t    reg_req_i,
    output logic [31:0]      rd_data_o,
    // Arbiter observation inputs
    input  wire logic        arb_in_use_i,
    input  wire arb_pins_t   pins_i,
    input  wire logic [4:0]  upper_state_i,
    input  wire logic [4:0]  lower_state_i,
    // Decoded view of the observed state
    output logic [2:0]       observed_agent_o,
    output arb_phase_t       observed_phase_o
);

    // Snapshot registers and their next values
    logic [7:0]  req_q;       // Request mirror
    logic [7:0]  req_d;       // Next request mirror
    logic [7:0]  gnt_q;       // Grant mirror
    logic [7:0]  gnt_d;       // Next grant mirror
    logic        sel_q;       // View select, one picks the upper machine
    logic        sel_d;       // Next view select
    logic [4:0]  state_q;     // Observed state code
    logic [4:0]  state_d;     // Next observed state code
    // Read data register
    logic [31:0] rd_q;        // Word shown on the read port
    logic [31:0] rd_d;        // Word chosen by the read mux

    // Asserted-high view of live pins
    logic [3:0]  ext_req;     // External requests, one means asserted
    logic [3:0]  ext_gnt;     // External grants, one means asserted
    logic [7:0]  live_req;    // Request byte as software sees it
    logic [7:0]  live_gnt;    // Grant byte as software sees it

    // External lines are active low; invert so one means asserted
    for (genvar i = 0; i < 4; i = i + 1) begin : g_ext_line
        // Request line of external agent i
        assign ext_req[i] = ~pins_i.ext_req_n[i];
        // Grant line of external agent i
        assign ext_gnt[i] = ~pins_i.ext_gnt_n[i];
    end

    // Controller lines are active high; bits 6:4 have no line behind them
    assign live_req = {pins_i.ctrl_req, 3'h0, ext_req};
    assign live_gnt = {pins_i.ctrl_gnt, 3'h0, ext_gnt};

    // Next values of the request and grant snapshots
    always_comb begin
        // Invalid view parks at the reset values
        req_d = REQ_SNAP_RST;
        gnt_d = GNT_SNAP_RST;
        // Mirrors follow pins only while arbiter in use
        if (arb_in_use_i) begin
            // Request field copies the live request bits
            req_d = live_req;
            // Grant field copies the live grant bits
            gnt_d = live_gnt;
        end
    end

    // Next value of the view select bit
    always_comb begin
        // Holds unless software writes the state register
        sel_d = sel_q;
        // Select bit is the only writable field; the rest is dropped
        if (reg_req_i.wr && (reg_req_i.addr == STATE_VIEW_ADDR)) begin
            sel_d = reg_req_i.wdata[SEL_BIT];
        end
    end

    // Next value of the observed state code
    always_comb begin
        // Unused arbiter shows the reset code
        state_d = CUR_STATE_RST;
        if (arb_in_use_i) begin
            if (sel_q == SEL_UPPER) begin
                // Upper machine code passes whole, slot codes included
                state_d = upper_state_i;
            end else begin
                // Lower machine has no slot, so the top bit is forced low
                state_d = {1'b0, lower_state_i[STATE_MSB-1:0]};
            end
        end
    end

    // Read mux, answered one cycle after the strobe
    always_comb begin
        // No read gives zero
        rd_d = 32'h0000_0000;
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == REQ_SNAP_ADDR) begin
                // Request word, reserved bits zero
                rd_d = {24'h00_0000, req_q};
            end else if (reg_req_i.addr == GNT_SNAP_ADDR) begin
                // Grant word, reserved bits zero
                rd_d = {24'h00_0000, gnt_q};
            end else if (reg_req_i.addr == STATE_VIEW_ADDR) begin
                // Select bit, two zero bits, then the state code
                rd_d = {24'h00_0000, sel_q, 2'h0, state_q};
            end else begin
                // Unmapped address reads zero
                rd_d = 32'h0000_0000;
            end
        end
    end

    // Register the snapshots
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Controller parked as owner, so only its grant bit set
            req_q <= REQ_SNAP_RST;
            gnt_q <= GNT_SNAP_RST;
        end else begin
            // Take the next snapshot values
            req_q <= req_d;
            gnt_q <= gnt_d;
        end
    end

    // Register the view select bit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Lower machine observed after reset
            sel_q <= SEL_RST;
        end else begin
            // Take the next select value
            sel_q <= sel_d;
        end
    end

    // Register the observed state code
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Reset code shown until the first edge after release
            state_q <= CUR_STATE_RST;
        end else begin
            // Take the next state code
            state_q <= state_d;
        end
    end

    // Register the read word
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Port idles at zero
            rd_q <= 32'h0000_0000;
        end else begin
            // Take the word chosen by the mux
            rd_q <= rd_d;
        end
    end

    // Outputs from flip-flops; code splits into agent and phase
    // Read word stands for one cycle, then falls back to zero
    assign rd_data_o        = rd_q;
    // Agent index 0..3, or 4 for the lower-level slot
    assign observed_agent_o = state_q[STATE_MSB:2];
    // Phase: prepare, grant busy, grant idle, owner
    assign observed_phase_o = arb_phase_t'(state_q[1:0]);

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Request snapshot copies the pins one edge later
    a_req_mirror_live: assert property (
        arb_in_use_i |=> req_q == {$past(pins_i.ctrl_req), 3'h0, ~$past(pins_i.ext_req_n)})
        else $error("request snapshot does not mirror pins");

    // Grant snapshot copies the pins one edge later
    a_gnt_mirror_live: assert property (
        arb_in_use_i |=> gnt_q == {$past(pins_i.ctrl_gnt), 3'h0, ~$past(pins_i.ext_gnt_n)})
        else $error("grant snapshot does not mirror pins");

    // Unused arbiter leaves the request snapshot at its reset value
    a_idle_reset_view: assert property (
        !arb_in_use_i |=> req_q == REQ_SNAP_RST)
        else $error("request snapshot not idle while arbiter unused");

    // Unused arbiter leaves the controller parked with the grant
    a_idle_grant_park: assert property (
        !arb_in_use_i |=> gnt_q == GNT_SNAP_RST)
        else $error("grant snapshot not parked while arbiter unused");

    // Unused arbiter shows the reset state code
    a_idle_state_code: assert property (
        !arb_in_use_i |=> state_q == CUR_STATE_RST)
        else $error("state code not idle while arbiter unused");

    // A write to the state register loads the select bit
    a_select_write_takes: assert property (
        reg_req_i.wr && reg_req_i.addr == STATE_VIEW_ADDR |=> sel_q == $past(reg_req_i.wdata[SEL_BIT]))
        else $error("select bit not written");

    // Without that write the select bit holds
    a_select_holds: assert property (
        !(reg_req_i.wr && reg_req_i.addr == STATE_VIEW_ADDR) |=> $stable(sel_q))
        else $error("select bit changed without a write");

    // Upper view shows the upper machine code whole
    a_upper_view_state: assert property (
        arb_in_use_i && sel_q == SEL_UPPER |=> state_q == $past(upper_state_i))
        else $error("upper machine state not shown");

    // Lower view shows the lower machine code without the slot bit
    a_lower_view_state: assert property (
        arb_in_use_i && sel_q == SEL_LOWER |=> state_q == {1'b0, $past(lower_state_i[3:0])})
        else $error("lower machine state not shown");

    // Lower view never shows a slot code
    a_lower_no_slot: assert property (
        sel_q == SEL_LOWER |=> !state_q[STATE_MSB])
        else $error("slot code shown in lower view");

    // State register read gives select, zeros and the code
    a_state_read_word: assert property (
        reg_req_i.rd && reg_req_i.addr == STATE_VIEW_ADDR
        |=> rd_data_o == {24'h00_0000, $past(sel_q), 2'h0, $past(state_q)})
        else $error("state register read wrong");

    // Request register read gives the snapshot
    a_req_read_word: assert property (
        reg_req_i.rd && reg_req_i.addr == REQ_SNAP_ADDR
        |=> rd_data_o == {24'h00_0000, $past(req_q)})
        else $error("request register read wrong");

    // Grant register read gives the snapshot
    a_gnt_read_word: assert property (
        reg_req_i.rd && reg_req_i.addr == GNT_SNAP_ADDR
        |=> rd_data_o == {24'h00_0000, $past(gnt_q)})
        else $error("grant register read wrong");

    // Read port falls back to zero without a read
    a_idle_read_zero: assert property (
        !reg_req_i.rd |=> rd_data_o == 32'h0000_0000)
        else $error("read data not zero without read");

    // Bits 31:8 and 6:5 of every word read zero
    a_reserved_read_zero: assert property (
        rd_data_o[31:8] == 24'h00_0000 && rd_data_o[6:5] == 2'h0)
        else $error("reserved read bits not zero");

    // Low code bits zero mean a prepare phase for the coded agent
    a_prepare_phase_code: assert property (
        arb_in_use_i && sel_q == SEL_UPPER && upper_state_i[1:0] == PH_PREPARE
        |=> observed_phase_o == PH_PREPARE
            && observed_agent_o == $past(upper_state_i[STATE_MSB:2]))
        else $error("prepare phase decode wrong");

    // Low code bits one mean grant given while the bus is held
    a_busy_phase_code: assert property (
        arb_in_use_i && sel_q == SEL_UPPER && upper_state_i[1:0] == PH_GNT_BUSY
        |=> observed_phase_o == PH_GNT_BUSY
            && observed_agent_o == $past(upper_state_i[STATE_MSB:2]))
        else $error("grant busy phase decode wrong");

    // Low code bits two mean grant given on an idle bus
    a_idle_phase_code: assert property (
        arb_in_use_i && sel_q == SEL_UPPER && upper_state_i[1:0] == PH_GNT_IDLE
        |=> observed_phase_o == PH_GNT_IDLE
            && observed_agent_o == $past(upper_state_i[STATE_MSB:2]))
        else $error("grant idle phase decode wrong");

    // Low code bits three mean the coded agent owns the bus
    a_owner_phase_code: assert property (
        arb_in_use_i && sel_q == SEL_UPPER && upper_state_i[1:0] == PH_OWNER
        |=> observed_phase_o == PH_OWNER
            && observed_agent_o == $past(upper_state_i[STATE_MSB:2]))
        else $error("owner phase decode wrong");

    // Main scenarios to be seen at least once
    // Upper machine shows the slot owning the bus
    c_upper_slot_owner: cover property (
        sel_q && state_q == 5'h13);
    // Lower machine shows its last agent granted on an idle bus
    c_lower_grant_idle: cover property (
        !sel_q && state_q == 5'h0e);
    // Select written, then a read of any register in the next cycle
    c_select_then_read: cover property (
        reg_req_i.wr && reg_req_i.addr == STATE_VIEW_ADDR ##1 reg_req_i.rd);
    // Controller gives up its parked grant
    c_ctrl_loses_grant: cover property (
        gnt_q[CTRL_BIT] ##1 !gnt_q[CTRL_BIT]);
    // Decoded view names the slot as owner
    c_slot_owner_decode: cover property (
        observed_agent_o == SLOT_LOWER && observed_phase_o == PH_OWNER);

endmodule
